// File: rtl/pitc_pkg.sv
// Constants, register map and types of the interrupt and trap controller.
// Assumes a single clock domain and an AHB-Lite register port.
// Function
// [RULE_01] Each source owns flags, trap number, vector.
// [RULE_02] Hardware trap vectors at once, ignoring masks.
// [RULE_03] Each hardware trap sets its trap flag bit; reset traps set no flag.
// [RULE_04] Trap preempts all but higher trap service; the code also holds off a trap while an equal class is in service.
// [RULE_05] Trap service blocks interrupts and event transfers.
// [RULE_06] Low byte holds state, high byte reserved.
// [RULE_07] Bits 15 to 8 read zero, writes ignored.
// [RULE_08] All low-byte bits writable in one access.
// [RULE_09] Group level bits 1:0, three ranks highest.
// [RULE_10] Priority level bits 5:2, Fh highest.
// [RULE_11] Bit 6 enables the source request.
// [RULE_12] Bit 7 is the request pending flag.
// [RULE_13] Same layout for every source register.
// [RULE_14] Reset first, class A own vectors, B shared.
// [RULE_15] Trap service forces cpu priority to 15.
// [RULE_16] Pick highest enabled level, group; clear on accept.
package pitc_pkg;
   // Field positions inside a control register
   localparam int GROUP_LEVEL_LSB = 0;
   localparam int PRIORITY_LEVEL_LSB = 2;
   localparam int EN_BIT   = 6;
   localparam int REQ_BIT  = 7;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   // Register map (byte addresses)
   localparam logic [11:0] CTRL_BASE   = 12'h000; // Source i at CTRL_BASE + 4*i
   localparam logic [11:0] TRAP_FLAGS  = 12'h100; // Trap flag register, write one to clear
   localparam logic [11:0] IRQ_STATUS  = 12'h104; // Sticky event status, write one to clear
   localparam logic [11:0] IRQ_MASK    = 12'h108; // Interrupt mask
   localparam logic [11:0] CPU_LEVEL   = 12'h10C; // Current cpu priority
   localparam logic [11:0] SERVICE_END = 12'h110; // Write: end of trap service
   // Trap numbers
   localparam logic [6:0] TRAPNO_RESET  = 7'h00;
   localparam logic [6:0] TRAPNO_NMI    = 7'h02;
   localparam logic [6:0] TRAPNO_STKOF  = 7'h04;
   localparam logic [6:0] TRAPNO_STKUF  = 7'h06;
   localparam logic [6:0] TRAPNO_CLASSB = 7'h0A;
   localparam logic [3:0] LEVEL_MAX     = 4'hF;
   // Trap classes by priority
   typedef enum logic [2:0] {
      PITC_NONE   = 3'h0,
      PITC_CLASSB = 3'h1,
      PITC_CLASSA = 3'h2,
      PITC_RESET  = 3'h3
   } pitc_class_e;
   // Status event bits
   localparam int EV_TRAP = 0;
   localparam int EV_ACK  = 1;
endpackage

// File: rtl/pitc_top.sv
// Prioritised interrupt and hardware trap controller.
// Assumes peripherals pulse requests synchronously and the cpu acknowledges vectors.
//
// Design decisions made here: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/10ps
module pitc_top #(
   parameter int NSRC = 23
) (
   input  wire logic              clk,
   input  wire logic              rst,
   // AHB-Lite slave
   input  wire logic              hsel,
   input  wire logic [11:0]       haddr,
   input  wire logic [1:0]        htrans,
   input  wire logic              hwrite,
   input  wire logic [2:0]        hsize,
   input  wire logic [31:0]       hwdata,
   input  wire logic              hready,
   output logic      [31:0]       hrdata,
   output logic                   hreadyout,
   output logic                   hresp,
   // Peripheral requests and trap conditions
   input  wire logic [NSRC-1:0]   src_req,
   input  wire logic [NSRC-1:0][6:0] src_trapno,
   input  wire logic              sw_reset_req,
   input  wire logic              wdt_overflow,
   input  wire logic              nmi_req,
   input  wire logic              stack_over,
   input  wire logic              stack_under,
   input  wire logic [4:0]        classb_req,
   // CPU side
   output logic                   cpu_irq,
   output logic      [6:0]        cpu_trapno,
   output logic      [8:0]        cpu_vector,
   output logic                   cpu_is_trap,
   input  wire logic              cpu_ack,
   output logic      [3:0]        cpu_current_priority,
   output logic                   peripheral_event_block,
   output logic                   irq
);
   // Whole register state
   typedef struct packed {
      logic [NSRC-1:0][7:0] ctrl;      // Per-source control low bytes
      logic [7:0]           trap_flag_register;
      logic [1:0]           status;
      logic [1:0]           mask;
      logic [3:0]           level;     // Cpu current priority
      pitc_pkg::pitc_class_e svc;      // Trap class in service
      logic                 busy;      // Vector presented
      logic [6:0]           trapno;
      logic                 is_trap;
      logic [4:0]           won;       // Winning source index
      logic                 dph;       // Data phase pending
      logic                 dwr;
      logic [11:0]          daddr;
      logic [31:0]          rdata;
   } pitc_state_s;

   pitc_state_s st;
   pitc_state_s next_st;

   // Arbitration results
   logic       win_valid;
   logic [4:0] win_idx;
   logic [5:0] win_key;
   pitc_pkg::pitc_class_e trap_cls;
   logic [6:0] trap_no;
   logic [7:0] trap_set;

   // Rank key: priority then group
   // Level sits in the upper four bits so it always dominates,
   // the group level only breaks ties between equal levels.
   function automatic logic [5:0] rank(input logic [7:0] c);
      rank = {c[pitc_pkg::PRIORITY_LEVEL_LSB +: 4], c[pitc_pkg::GROUP_LEVEL_LSB +: 2]}; // RULE_09 RULE_10
   endfunction

   // Highest priority enabled pending source
   always_comb begin
      win_valid = 1'b0;
      win_idx   = 5'h00;
      win_key   = 6'h00;
      for (int i = 0; i < NSRC; i++) begin
         if (st.ctrl[i][pitc_pkg::REQ_BIT] && st.ctrl[i][pitc_pkg::EN_BIT]) begin // RULE_11 RULE_16
            if (!win_valid || rank(st.ctrl[i]) > win_key) begin
               win_valid = 1'b1;
               win_idx   = 5'(i);
               win_key   = rank(st.ctrl[i]);
            end
         end
      end
   end

   // Trap classification, reset highest, class B lowest
   always_comb begin
      trap_set = {2'h0, classb_req != 5'h00, 1'b0, stack_under, stack_over, nmi_req, 1'b0}; // RULE_03
      trap_cls = pitc_pkg::PITC_NONE;
      trap_no  = pitc_pkg::TRAPNO_CLASSB;
      if (sw_reset_req || wdt_overflow) begin // RULE_14
         trap_cls = pitc_pkg::PITC_RESET;
         trap_no  = pitc_pkg::TRAPNO_RESET;
      end else if (nmi_req) begin
         trap_cls = pitc_pkg::PITC_CLASSA;
         trap_no  = pitc_pkg::TRAPNO_NMI;
      end else if (stack_over) begin
         trap_cls = pitc_pkg::PITC_CLASSA;
         trap_no  = pitc_pkg::TRAPNO_STKOF;
      end else if (stack_under) begin
         trap_cls = pitc_pkg::PITC_CLASSA;
         trap_no  = pitc_pkg::TRAPNO_STKUF;
      end else if (classb_req != 5'h00) begin
         trap_cls = pitc_pkg::PITC_CLASSB;
         trap_no  = pitc_pkg::TRAPNO_CLASSB;
      end
   end

   // Next state
   always_comb begin
      logic [7:0] wb;
      logic       acc;
      wb      = hwdata[7:0];
      acc     = 1'b0;
      next_st = st;
      // Requests from sources are sticky
      for (int i = 0; i < NSRC; i++) begin
         if (src_req[i]) begin
            next_st.ctrl[i][pitc_pkg::REQ_BIT] = 1'b1; // RULE_12
         end
      end
      // Bus data phase
      // Writes land at the end of the data phase, one cycle
      // after the address was taken; only the low byte is kept.
      if (st.dph && st.dwr) begin
         if (st.daddr < pitc_pkg::CTRL_BASE + 12'(4 * NSRC)) begin
            for (int i = 0; i < NSRC; i++) begin
               if (st.daddr[11:2] == 10'(i)) begin
                  next_st.ctrl[i] = wb; // RULE_07 RULE_08 RULE_13
                  if (src_req[i]) begin
                     next_st.ctrl[i][pitc_pkg::REQ_BIT] = 1'b1;
                  end
               end
            end
         end else if (st.daddr == pitc_pkg::TRAP_FLAGS) begin
            next_st.trap_flag_register = st.trap_flag_register & ~wb;
         end else if (st.daddr == pitc_pkg::IRQ_STATUS) begin
            next_st.status = st.status & ~wb[1:0];
         end else if (st.daddr == pitc_pkg::IRQ_MASK) begin
            next_st.mask = wb[1:0];
         end else if (st.daddr == pitc_pkg::CPU_LEVEL) begin
            next_st.level = wb[3:0];
         end else if (st.daddr == pitc_pkg::SERVICE_END) begin
            next_st.svc = pitc_pkg::PITC_NONE;
         end
      end
      // Trap flags, set wins over clear
      next_st.trap_flag_register = next_st.trap_flag_register | trap_set; // RULE_03
      // Trap preempts unless an equal or higher class is in service
      if (trap_cls != pitc_pkg::PITC_NONE && trap_cls > st.svc) begin // RULE_02 RULE_04
         next_st.busy    = 1'b1;
         next_st.trapno  = trap_no;
         next_st.is_trap = 1'b1;
         next_st.svc     = trap_cls;
         next_st.level   = pitc_pkg::LEVEL_MAX; // RULE_15
         next_st.status[pitc_pkg::EV_TRAP] = 1'b1;
      end else if (st.busy && cpu_ack) begin
         next_st.busy = 1'b0;
         acc          = !st.is_trap;
         next_st.is_trap = 1'b0;
      end else if (!st.busy && win_valid && st.svc == pitc_pkg::PITC_NONE // RULE_05
                   && win_key[5:2] > st.level) begin
         next_st.busy    = 1'b1;
         next_st.won     = win_idx;
         next_st.trapno  = src_trapno[win_idx]; // RULE_01
         next_st.is_trap = 1'b0;
      end
      // Accepted request clears its flag
      // A source still requesting in this cycle keeps its flag,
      // so a fresh event is never lost behind the acknowledge.
      if (acc) begin
         next_st.ctrl[st.won][pitc_pkg::REQ_BIT] = src_req[st.won]; // RULE_16
         next_st.level = st.ctrl[st.won][pitc_pkg::PRIORITY_LEVEL_LSB +: 4];
         next_st.status[pitc_pkg::EV_ACK] = 1'b1;
      end
      // Address phase capture
      next_st.dph = hsel && hready && htrans[1];
      if (hsel && hready && htrans[1]) begin
         next_st.dwr   = hwrite;
         next_st.daddr = {haddr[11:2], 2'b00};
      end
      // Read data, high bits zero
      // Decoded from the live address so it stands in the data phase;
      // unmapped addresses read as zero.
      next_st.rdata = 32'h0000_0000; // RULE_06
      if (haddr < pitc_pkg::CTRL_BASE + 12'(4 * NSRC)) begin
         for (int i = 0; i < NSRC; i++) begin
            if (haddr[11:2] == 10'(i)) begin
               next_st.rdata = {24'h00_0000, next_st.ctrl[i]}; // RULE_07
            end
         end
      end else if (haddr[11:2] == pitc_pkg::TRAP_FLAGS[11:2]) begin
         next_st.rdata = {24'h00_0000, next_st.trap_flag_register};
      end else if (haddr[11:2] == pitc_pkg::IRQ_STATUS[11:2]) begin
         next_st.rdata = {30'h0, next_st.status};
      end else if (haddr[11:2] == pitc_pkg::IRQ_MASK[11:2]) begin
         next_st.rdata = {30'h0, next_st.mask};
      end else if (haddr[11:2] == pitc_pkg::CPU_LEVEL[11:2]) begin
         next_st.rdata = {28'h0, next_st.level};
      end
   end

   // State register
   always_ff @(posedge clk) begin
      if (rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   // Outputs
   assign hrdata                 = st.rdata;
   assign hreadyout              = 1'b1;
   assign hresp                  = 1'b0;
   assign cpu_irq                = st.busy;
   assign cpu_trapno             = st.trapno;
   assign cpu_vector             = {st.trapno, 2'b00}; // RULE_01
   assign cpu_is_trap            = st.is_trap;
   assign cpu_current_priority   = st.level;
   assign peripheral_event_block = st.svc != pitc_pkg::PITC_NONE; // RULE_05
   assign irq                    = |(st.status & st.mask);

   // Reset trap vectored at maximum level next cycle
   AST_TRAP_LEVEL: assert property (@(posedge clk) disable iff (rst) // RULE_15
      (trap_cls == pitc_pkg::PITC_RESET && st.svc != pitc_pkg::PITC_RESET)
      |=> (cpu_current_priority == 4'hF && cpu_is_trap && cpu_trapno == 7'h00))
      else $error("reset trap not vectored at level 15");
   AST_NMI_FLAG: assert property (@(posedge clk) disable iff (rst) // RULE_03
      nmi_req |=> st.trap_flag_register[1])
      else $error("nmi trap flag not set");
   AST_VECTOR: assert property (@(posedge clk) disable iff (rst) // RULE_01
      cpu_irq |-> (cpu_vector == {cpu_trapno, 2'b00}
                   && (cpu_is_trap || cpu_trapno == src_trapno[st.won])))
      else $error("vector not bound to winning source");
   AST_BLOCK: assert property (@(posedge clk) disable iff (rst) // RULE_05
      ($past(st.svc) != pitc_pkg::PITC_NONE && $rose(cpu_irq)) |-> cpu_is_trap)
      else $error("interrupt entered during trap service");
   AST_NOPREEMPT: assert property (@(posedge clk) disable iff (rst) // RULE_04
      (st.svc == pitc_pkg::PITC_RESET) |=> st.svc inside {pitc_pkg::PITC_RESET, pitc_pkg::PITC_NONE})
      else $error("reset service preempted");
   AST_HIGHZERO: assert property (@(posedge clk) disable iff (rst) // RULE_07
      $past(st.dph) |-> hrdata[15:8] == 8'h00)
      else $error("reserved bits not zero");
   AST_ENABLE: assert property (@(posedge clk) disable iff (rst) // RULE_11
      ($rose(cpu_irq) && !cpu_is_trap) |-> $past(st.ctrl[win_idx][6]))
      else $error("disabled source won");
   AST_CLEAR: assert property (@(posedge clk) disable iff (rst) // RULE_16
      (cpu_irq && cpu_ack && !cpu_is_trap && trap_cls == pitc_pkg::PITC_NONE && !src_req[st.won]
       && !(st.dph && st.dwr)) |=> !st.ctrl[$past(st.won)][7])
      else $error("accepted flag not cleared");

   // Stack overflow condition leaves its own flag behind
   AST_FLAG_STKOF: assert property (@(posedge clk) disable iff (rst) // RULE_03
      stack_over |=> st.trap_flag_register[2])
      else $error("stack overflow flag not set");

   // Stack underflow flag
   AST_FLAG_STKUF: assert property (@(posedge clk) disable iff (rst) // RULE_03
      stack_under |=> st.trap_flag_register[3])
      else $error("stack underflow flag not set");

   // Any class B condition sets the shared flag
   AST_FLAG_CLASSB: assert property (@(posedge clk) disable iff (rst) // RULE_03
      (classb_req != 5'h00) |=> st.trap_flag_register[5])
      else $error("class B flag not set");

   // Trap above the class in service vectored next cycle whatever the masks and enables
   AST_TRAP_NOMASK: assert property (@(posedge clk) disable iff (rst) // RULE_02
      (trap_cls != pitc_pkg::PITC_NONE && trap_cls > st.svc)
      |=> (cpu_irq && cpu_is_trap && cpu_trapno == $past(trap_no)))
      else $error("trap not vectored at once");

   // Class B conditions share one trap number
   AST_CLASSB_SHARED: assert property (@(posedge clk) disable iff (rst) // RULE_14
      (trap_cls == pitc_pkg::PITC_CLASSB && st.svc == pitc_pkg::PITC_NONE)
      |=> cpu_trapno == pitc_pkg::TRAPNO_CLASSB)
      else $error("class B trap number wrong");

   // Reset class always wins the service
   AST_RESET_TOP: assert property (@(posedge clk) disable iff (rst) // RULE_14
      (trap_cls == pitc_pkg::PITC_RESET) |=> st.svc == pitc_pkg::PITC_RESET)
      else $error("reset trap not in service");

   // Class A service only yields to reset or its own end
   AST_CLASSA_HOLD: assert property (@(posedge clk) disable iff (rst) // RULE_04
      (st.svc == pitc_pkg::PITC_CLASSA && trap_cls != pitc_pkg::PITC_RESET)
      |=> st.svc inside {pitc_pkg::PITC_CLASSA, pitc_pkg::PITC_NONE})
      else $error("class A service preempted");

   // Every trap taken forces the top level
   AST_LEVEL_MAX: assert property (@(posedge clk) disable iff (rst) // RULE_15
      (trap_cls != pitc_pkg::PITC_NONE && trap_cls > st.svc)
      |=> cpu_current_priority == pitc_pkg::LEVEL_MAX)
      else $error("trap did not force level 15");

   // No interrupt entry while a trap is in service
   AST_EVENT_BLOCK: assert property (@(posedge clk) disable iff (rst) // RULE_05
      (peripheral_event_block && !cpu_irq && trap_cls == pitc_pkg::PITC_NONE) |=> !cpu_irq)
      else $error("interrupt entered under trap service");

   // Control register reads carry nothing above the low byte
   AST_CTRL_HIGH: assert property (@(posedge clk) disable iff (rst) // RULE_06
      (st.dph && !st.dwr && st.daddr < pitc_pkg::CTRL_BASE + 12'(4 * NSRC))
      |-> hrdata[31:8] == 24'h00_0000)
      else $error("control read high bits not zero");

   // One word write reprograms the whole low byte
   AST_WRITE_LOW: assert property (@(posedge clk) disable iff (rst) // RULE_08
      (st.dph && st.dwr && st.daddr == pitc_pkg::CTRL_BASE && !src_req[0] && !(st.busy && cpu_ack))
      |=> st.ctrl[0] == $past(hwdata[7:0]))
      else $error("control write not taken whole");

   // A request pulse always leaves the flag set
   AST_REQ_STICKY: assert property (@(posedge clk) disable iff (rst) // RULE_12
      src_req[0] |=> st.ctrl[0][pitc_pkg::REQ_BIT])
      else $error("request flag not set");

   // An interrupt is only entered above the current level
   AST_ARB_ABOVE: assert property (@(posedge clk) disable iff (rst) // RULE_10
      ($rose(cpu_irq) && !cpu_is_trap) |-> $past(st.ctrl[win_idx][5:2]) > $past(st.level))
      else $error("interrupt entered at or below current level");

   // Accepting an interrupt moves the cpu to its level
   AST_LEVEL_ACCEPT: assert property (@(posedge clk) disable iff (rst) // RULE_16
      (cpu_irq && cpu_ack && !cpu_is_trap && trap_cls == pitc_pkg::PITC_NONE)
      |=> cpu_current_priority == $past(st.ctrl[st.won][5:2]))
      else $error("level not taken from accepted source");
endmodule

// File: bench/pitc_cpu_model.sv
// CPU core model: takes each presented vector after a set delay.
// Assumes cpu_irq stands until cpu_ack is sampled high.
`timescale 1ns/10ps
module pitc_cpu_model (
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       cpu_irq,
   input  wire logic [1:0] dly,
   output logic            cpu_ack
);
   logic [1:0] wait_cnt; // Cycles a vector has waited
   // One-cycle ack once the wait reaches the delay
   always_ff @(posedge clk) begin
      if (rst || cpu_ack) begin
         cpu_ack  <= 1'b0;
         wait_cnt <= 2'h0;
      end else if (cpu_irq && wait_cnt >= dly) begin
         cpu_ack <= 1'b1;
      end else if (cpu_irq) begin
         wait_cnt <= wait_cnt + 2'h1;
      end
   end
endmodule

// File: bench/pitc_top_tb.sv
// Self-checking bench of the interrupt and trap controller.
// Assumes a zero-wait AHB-Lite slave and the cpu model beside it.
`timescale 1ns/10ps
module pitc_top_tb;
   localparam int NSRC = 23;
   logic                   clk, rst, hsel, hwrite, hreadyout, hresp;
   logic                   cpu_irq, cpu_is_trap, cpu_ack, irq, peb;
   logic                   sw_reset_req, wdt_overflow, nmi_req, stack_over, stack_under;
   logic [1:0]             htrans, dly;
   logic [2:0]             hsize;
   logic [11:0]            haddr;
   logic [31:0]            hwdata, hrdata, rd, w;
   logic [NSRC-1:0]        src_req;
   logic [NSRC-1:0][6:0]   src_trapno;
   logic [4:0]             classb_req;
   logic [6:0]             cpu_trapno;
   logic [8:0]             cpu_vector;
   logic [3:0]             cpu_level;
   logic [7:0]             cfg [4] = '{8'h54, 8'h57, 8'h58, 8'h3F}; // Level 5/5/6, last disabled
   int                     ord [3] = '{2, 1, 0};                    // Expected win order
   int                     num_errors = 0;
   int                     comparisons = 0;
   pitc_top #(.NSRC(NSRC)) dut (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .src_req(src_req), .src_trapno(src_trapno),
      .sw_reset_req(sw_reset_req), .wdt_overflow(wdt_overflow), .nmi_req(nmi_req),
      .stack_over(stack_over), .stack_under(stack_under), .classb_req(classb_req),
      .cpu_irq(cpu_irq), .cpu_trapno(cpu_trapno), .cpu_vector(cpu_vector), .cpu_is_trap(cpu_is_trap),
      .cpu_ack(cpu_ack), .cpu_current_priority(cpu_level), .peripheral_event_block(peb), .irq(irq));
   pitc_cpu_model cpu (.clk(clk), .rst(rst), .cpu_irq(cpu_irq), .dly(dly), .cpu_ack(cpu_ack));
   // Free-running clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // Compare and count
   task chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // One AHB-Lite single word transfer
   task bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      hsel   <= 1'b1;
      htrans <= 2'h2;
      haddr  <= a;
      hwrite <= wr;
      do @(posedge clk); while (hreadyout !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask
   // Wait for the cpu to take a vector, check what stands
   task acc(input logic [6:0] tn, input logic it);
      int n;
      for (n = 0; n < 50 && cpu_ack !== 1'b1; n++) @(negedge clk);
      chk(32'({cpu_ack, it ? cpu_is_trap : 1'b0, cpu_vector, cpu_trapno}), 32'({1'b1, it, tn, 2'h0, tn}));
      @(posedge clk);
   endtask
   // Verdict
   task results;
      $display("comparisons %0d mismatches %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // Watchdog
   initial begin
      #100000;
      num_errors++;
      results;
   end
   // Main sequence
   initial begin
      void'($urandom(96));
      {hsel, hwrite, htrans, haddr, hwdata, src_req, dly} = '0;
      {sw_reset_req, wdt_overflow, nmi_req, stack_over, stack_under, classb_req} = '0;
      hsize = 3'h2;
      for (int i = 0; i < NSRC; i++) src_trapno[i] = 7'h10 + 7'($urandom % 112);
      rst = 1'b1;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      bus(1'b0, pitc_pkg::CTRL_BASE, 32'h0);
      chk(rd, 32'h0);
      bus(1'b0, 12'h200, 32'h0);
      chk(rd, 32'h0);
      bus(1'b1, pitc_pkg::CPU_LEVEL, 32'hF);
      for (int i = 0; i < NSRC; i++) begin
         w = $urandom;
         bus(1'b1, 12'(4 * i), w);
         bus(1'b0, 12'(4 * i), 32'h0);
         chk(rd, {24'h0, w[7:0]});
         bus(1'b1, 12'(4 * i), 32'h0);
      end
      $display("test registers done");
      for (int i = 0; i < 4; i++) bus(1'b1, 12'(4 * i), {24'h0, cfg[i]});
      @(posedge clk);
      src_req <= 23'hF;
      @(posedge clk);
      src_req <= '0;
      for (int k = 0; k < 3; k++) begin
         dly <= 2'($urandom % 4);
         bus(1'b1, pitc_pkg::CPU_LEVEL, 32'h0);
         acc(src_trapno[ord[k]], 1'b0);
         bus(1'b0, pitc_pkg::CPU_LEVEL, 32'h0);
         chk(rd, 32'(cfg[ord[k]][5:2]));
      end
      bus(1'b0, 12'hC, 32'h0);
      chk(rd, 32'hBF);
      bus(1'b0, 12'h8, 32'h0);
      chk(rd, 32'h58);
      $display("test arbitration done");
      bus(1'b1, pitc_pkg::IRQ_MASK, 32'h3);
      @(posedge clk);
      classb_req <= 5'h01;
      @(posedge clk);
      classb_req <= 5'h00;
      acc(pitc_pkg::TRAPNO_CLASSB, 1'b1);
      @(negedge clk);
      chk(32'({peb, cpu_level}), 32'h1F);
      @(posedge clk);
      stack_over <= 1'b1;
      @(posedge clk);
      stack_over <= 1'b0;
      acc(pitc_pkg::TRAPNO_STKOF, 1'b1);
      bus(1'b0, pitc_pkg::TRAP_FLAGS, 32'h0);
      chk(rd, 32'h24);
      chk(32'(irq), 32'h1);
      bus(1'b1, pitc_pkg::TRAP_FLAGS, 32'h24);
      bus(1'b0, pitc_pkg::TRAP_FLAGS, 32'h0);
      chk(rd, 32'h0);
      bus(1'b1, pitc_pkg::IRQ_STATUS, 32'h3);
      bus(1'b1, pitc_pkg::SERVICE_END, 32'h0);
      bus(1'b1, pitc_pkg::SERVICE_END, 32'h0);
      bus(1'b1, pitc_pkg::IRQ_MASK, 32'h0);
      @(negedge clk);
      chk(32'({irq, peb}), 32'h0);
      @(posedge clk);
      nmi_req <= 1'b1;
      @(posedge clk);
      nmi_req <= 1'b0;
      acc(pitc_pkg::TRAPNO_NMI, 1'b1);
      chk(32'(irq), 32'h0);
      bus(1'b1, pitc_pkg::IRQ_MASK, 32'h1);
      @(negedge clk);
      chk(32'(irq), 32'h1);
      @(posedge clk);
      stack_under <= 1'b1;
      @(posedge clk);
      stack_under <= 1'b0;
      repeat (3) @(negedge clk);
      chk(32'(cpu_irq), 32'h0);
      @(posedge clk);
      wdt_overflow <= 1'b1;
      @(posedge clk);
      wdt_overflow <= 1'b0;
      acc(pitc_pkg::TRAPNO_RESET, 1'b1);
      @(negedge clk);
      chk(32'({peb, cpu_level}), 32'h1F);
      bus(1'b0, pitc_pkg::TRAP_FLAGS, 32'h0);
      chk(rd, 32'h0A);
      $display("test traps done");
      results;
   end
endmodule
